// [core/desvo_buf.sv]
// two-entry pixel buffer with valid and ready on both sides
`timescale 1ns/1ps
module desvo_buf (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  // filling side
  desvo_stream_if.snk wr,
  // draining side
  desvo_stream_if.src rd
);

  logic [13:0] mem_q [0:1];
  logic [13:0] mem_d [0:1];
  logic        wr_ptr_q, wr_ptr_d;
  logic        rd_ptr_q, rd_ptr_d;
  logic [1:0]  count_q, count_d;
  logic        not_full_q, not_full_d;
  logic        push, pop;

  // ready is registered so the link side sees a clean level
  assign wr.ready      = not_full_q;
  assign rd.valid      = (count_q != 2'h0);
  assign rd.data       = mem_q[rd_ptr_q][11:0];
  assign rd.line_sync  = mem_q[rd_ptr_q][12];
  assign rd.frame_sync = mem_q[rd_ptr_q][13];
  assign push          = wr.valid & not_full_q;
  assign pop           = rd.valid & rd.ready;

  // next pointers and count
  always_comb begin
    wr_ptr_d   = push ? ~wr_ptr_q : wr_ptr_q;
    rd_ptr_d   = pop ? ~rd_ptr_q : rd_ptr_q;
    count_d    = count_q + {1'b0, push} - {1'b0, pop};
    not_full_d = (count_d != desvo_pkg::BUF_FULL_COUNT);
  end

  // per-entry write
  for (genvar i = 0; i < desvo_pkg::BUF_DEPTH; i++) begin : g_ent
    always_comb begin
      mem_d[i] = mem_q[i];
      if (push && (wr_ptr_q == 1'(i))) begin
        mem_d[i] = {wr.frame_sync, wr.line_sync, wr.data};
      end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[i] <= 14'h0000;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // register state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q   <= 1'b0;
      rd_ptr_q   <= 1'b0;
      count_q    <= 2'h0;
      not_full_q <= 1'b0;
    end else begin
      wr_ptr_q   <= wr_ptr_d;
      rd_ptr_q   <= rd_ptr_d;
      count_q    <= count_d;
      not_full_q <= not_full_d;
    end
  end

endmodule

// [core/desvo_top.sv]
// parallel pixel output stage of the serial link deserializer
`timescale 1ns/1ps

module desvo_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // decoded pixels from the link receiver
  input  wire logic        pix_valid,
  input  wire logic [11:0] pix_data,
  input  wire logic        pix_line_sync,
  input  wire logic        pix_frame_sync,
  output logic             pix_ready,
  input  wire logic        link_locked,
  // configuration
  input  wire logic [1:0]  mode,
  input  wire logic        strobe_edge_select,
  // parallel video pins
  output logic [11:0]      parallel_data_out,
  output logic             line_sync,
  output logic             frame_sync,
  output logic             pclk_out,
  output logic             lock_out,
  input  wire logic        video_stall,
  // auxiliary pins
  input  wire logic [1:0]  aux_is_output,
  input  wire logic [1:0]  aux_local_val,
  input  wire logic [1:0]  aux_pin_i,
  output logic [1:0]       aux_pin_o,
  output logic [1:0]       aux_pin_oe,
  output logic [1:0]       fwd_remote_aux_output
);

  // ----------------------------------------------------------------
  // buffer in the pixel path
  // ----------------------------------------------------------------
  desvo_stream_if in_if ();
  desvo_stream_if out_if ();

  assign in_if.valid      = pix_valid;
  assign in_if.data       = pix_data;
  assign in_if.line_sync  = pix_line_sync;
  assign in_if.frame_sync = pix_frame_sync;
  assign pix_ready        = in_if.ready;

  desvo_buf desvo_buf_i (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr      (in_if.snk),
    .rd      (out_if.src)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic       stall_m_q, stall_s_q;
  logic [1:0] aux_m_q, aux_s_q;

  // two stages each; only the second stage is read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_m_q <= 1'b0;
      stall_s_q <= 1'b0;
      aux_m_q   <= 2'h0;
      aux_s_q   <= 2'h0;
    end else begin
      stall_m_q <= video_stall;
      stall_s_q <= stall_m_q;
      aux_m_q   <= aux_pin_i;
      aux_s_q   <= aux_m_q;
    end
  end

  // ----------------------------------------------------------------
  // lock sequencer
  // ----------------------------------------------------------------
  desvo_pkg::desvo_state_t state_q, state_d;
  logic [3:0] lead_q, lead_d;
  logic       lock_q, lock_d;

  // the pixel clock runs in every state but off
  always_comb begin
    state_d = state_q;
    lead_d  = lead_q;
    case (state_q)
      desvo_pkg::ST_OFF: begin
        lead_d = 4'h0;
        if (link_locked) begin
          if (mode == desvo_pkg::MODE_HIGH_FREQ) begin
            state_d = desvo_pkg::ST_LOCKED;
          end else begin
            state_d = desvo_pkg::ST_LEAD;
          end
        end
      end
      desvo_pkg::ST_LEAD: begin
        lead_d = lead_q + 4'h1;
        if (!link_locked) begin
          state_d = desvo_pkg::ST_OFF;
        end else if (lead_q == desvo_pkg::LEAD_CYCLES - 4'h1) begin
          state_d = desvo_pkg::ST_LOCKED;
        end
      end
      desvo_pkg::ST_LOCKED: begin
        if (!link_locked) begin
          state_d = desvo_pkg::ST_OFF;
        end
      end
      default: begin
        state_d = desvo_pkg::ST_OFF;
      end
    endcase
    lock_d = (state_d == desvo_pkg::ST_LOCKED);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= desvo_pkg::ST_OFF;
      lead_q  <= 4'h0;
      lock_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      lead_q  <= lead_d;
      lock_q  <= lock_d;
    end
  end

  assign lock_out = lock_q;

  // ----------------------------------------------------------------
  // pixel clock and output register
  // ----------------------------------------------------------------
  logic        pclk_q, pclk_d;
  logic        launch;
  logic [11:0] mask;
  logic [11:0] data_q, data_d;
  logic        ls_q, ls_d;
  logic        fs_q, fs_d;

  // width per mode; rates above sys_clk/2 belong to the link side
  always_comb begin
    if (mode == desvo_pkg::MODE_TEN_BIT) begin
      mask = desvo_pkg::MASK_TEN_BIT;
    end else begin
      mask = desvo_pkg::MASK_TWELVE_BIT;
    end
  end

  // launch on the edge opposite the strobe, so data is settled
  // half a pixel period before the receiver samples it
  always_comb begin
    if (state_d != desvo_pkg::ST_OFF) begin
      pclk_d = ~pclk_q;
    end else begin
      pclk_d = desvo_pkg::PCLK_IDLE;
    end
    launch = (state_d != desvo_pkg::ST_OFF) &&
             (pclk_d != strobe_edge_select) && !stall_s_q;
  end

  assign out_if.ready = launch;

  // a word is held, not dropped, when nothing new is ready
  always_comb begin
    data_d = data_q;
    ls_d   = ls_q;
    fs_d   = fs_q;
    if (state_d == desvo_pkg::ST_OFF) begin
      data_d = desvo_pkg::DATA_RESET;
      ls_d   = 1'b0;
      fs_d   = 1'b0;
    end else if (launch && out_if.valid) begin
      data_d = out_if.data & mask;
      ls_d   = out_if.line_sync;
      fs_d   = out_if.frame_sync;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_q <= desvo_pkg::PCLK_IDLE;
      data_q <= desvo_pkg::DATA_RESET;
      ls_q   <= 1'b0;
      fs_q   <= 1'b0;
    end else begin
      pclk_q <= pclk_d;
      data_q <= data_d;
      ls_q   <= ls_d;
      fs_q   <= fs_d;
    end
  end

  assign pclk_out          = pclk_q;
  assign parallel_data_out = data_q;
  assign line_sync         = ls_q;
  assign frame_sync        = fs_q;

  // ----------------------------------------------------------------
  // auxiliary pins, one slice per pin
  // ----------------------------------------------------------------
  logic [1:0] aux_o_q, aux_o_d;
  logic [1:0] aux_oe_q, aux_oe_d;
  logic [1:0] fwd_q, fwd_d;

  for (genvar i = 0; i < 2; i++) begin : g_aux
    // an output pin forwards nothing, so the remote sees low
    always_comb begin
      aux_oe_d[i] = aux_is_output[i];
      aux_o_d[i]  = aux_is_output[i] & aux_local_val[i];
      fwd_d[i]    = ~aux_is_output[i] & aux_s_q[i];
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        aux_o_q[i]  <= 1'b0;
        aux_oe_q[i] <= 1'b0;
        fwd_q[i]    <= 1'b0;
      end else begin
        aux_o_q[i]  <= aux_o_d[i];
        aux_oe_q[i] <= aux_oe_d[i];
        fwd_q[i]    <= fwd_d[i];
      end
    end
  end

  assign aux_pin_o             = aux_o_q;
  assign aux_pin_oe            = aux_oe_q;
  assign fwd_remote_aux_output = fwd_q;

endmodule

// [include/desvo_pkg.sv]
// constants and types shared by the parallel video output block
package desvo_pkg;

  // ----------------------------------------------------------------
  // operating modes on the mode input
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_TEN_BIT       = 2'h0;
  localparam logic [1:0] MODE_LOW_FREQ      = 2'h1; // low_freq_mode
  localparam logic [1:0] MODE_HIGH_FREQ     = 2'h2; // high_freq_mode

  // ----------------------------------------------------------------
  // data path layout
  // ----------------------------------------------------------------
  localparam int         DATA_W             = 12;
  localparam logic [11:0] MASK_TEN_BIT      = 12'h3ff;
  localparam logic [11:0] MASK_TWELVE_BIT   = 12'hfff;
  localparam logic [11:0] DATA_RESET        = 12'h000;
  localparam int         BUF_DEPTH          = 2;
  localparam logic [1:0] BUF_FULL_COUNT     = 2'h2;

  // ----------------------------------------------------------------
  // pixel clock ranges of the link, in kHz, per mode
  // ----------------------------------------------------------------
  localparam int         LOW_FREQ_MIN_KHZ   = 25000;
  localparam int         LOW_FREQ_MAX_KHZ   = 50000;
  localparam int         HIGH_FREQ_MIN_KHZ  = 37500;
  localparam int         HIGH_FREQ_MAX_KHZ  = 75000;
  localparam int         TEN_MIN_KHZ        = 50000;
  localparam int         TEN_MAX_KHZ        = 100000;

  // ----------------------------------------------------------------
  // start-up timing
  // ----------------------------------------------------------------
  localparam int         LEAD_PCLK_PERIODS  = 4;
  localparam int         SYS_PER_PCLK       = 2;
  localparam logic [3:0] LEAD_CYCLES        =
    4'(LEAD_PCLK_PERIODS * SYS_PER_PCLK);
  localparam logic       PCLK_IDLE          = 1'b0;

  // lock sequencer states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_LEAD,
    ST_LOCKED
  } desvo_state_t;

endpackage

// [include/desvo_stream_if.sv]
// pixel stream carrier between the buffer and the output stage
`timescale 1ns/1ps
interface desvo_stream_if;
  logic        valid;
  logic        ready;
  logic [11:0] data;
  logic        line_sync;
  logic        frame_sync;

  modport src (output valid, output data, output line_sync,
               output frame_sync, input ready);
  modport snk (input valid, input data, input line_sync,
               input frame_sync, output ready);
endinterface

// [verification/desvo_sink.sv]
// downstream video processor model on the parallel pins
`timescale 1ns/1ps
module desvo_sink (
  // pins from the deserializer
  input  wire logic        sys_clk,
  input  wire logic        pclk_out,
  input  wire logic        lock_out,
  input  wire logic        strobe_edge_select,
  input  wire logic [11:0] parallel_data_out,
  input  wire logic        line_sync,
  input  wire logic        frame_sync,
  // bench control: bit 1 holds off, bit 0 stalls at random
  input  wire logic [1:0]  stall_mode,
  // hold-off pin back to the deserializer
  output logic             video_stall
);
  logic [13:0] got_q[$];
  logic [13:0] last_q = 14'h0000;
  initial video_stall = 1'b0;
  // pre-edge values: pclk about to reach the strobe level samples the
  // pixel launched one edge earlier; a repeat is not a new word
  always @(posedge sys_clk) begin
    if (!lock_out)
      last_q = 14'h0000;
    else if (pclk_out != strobe_edge_select &&
             {parallel_data_out, line_sync, frame_sync} != last_q) begin
      last_q = {parallel_data_out, line_sync, frame_sync};
      got_q.push_back(last_q);
    end
    video_stall <= stall_mode[1] | stall_mode[0] & 1'($urandom);
  end
endmodule

// [verification/desvo_top_chk.sv]
// port assertions for the parallel video output stage
`timescale 1ns/1ps
module desvo_top_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // watched ports
  input wire logic        link_locked,
  input wire logic [1:0]  mode,
  input wire logic        strobe_edge_select,
  input wire logic [11:0] parallel_data_out,
  input wire logic        line_sync,
  input wire logic        frame_sync,
  input wire logic        pclk_out,
  input wire logic        lock_out,
  input wire logic [1:0]  aux_is_output,
  input wire logic [1:0]  aux_local_val,
  input wire logic [1:0]  aux_pin_o,
  input wire logic [1:0]  aux_pin_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // mode 3 sequences like the non high-frequency modes
  wire logic        fast = mode == desvo_pkg::MODE_HIGH_FREQ;
  wire logic [13:0] pix  = {parallel_data_out, line_sync, frame_sync};
  property p_ten_mask;
    mode == desvo_pkg::MODE_TEN_BIT |-> parallel_data_out[11:10] == 2'h0;
  endproperty
  a_ten_mask: assert property (p_ten_mask)
    else $error("upper data bits active in ten-bit mode");
  property p_idle;
    !link_locked |=> !pclk_out && !lock_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("clock or lock left on without link");
  property p_run;
    lock_out |-> pclk_out != $past(pclk_out);
  endproperty
  a_run: assert property (p_run)
    else $error("lock shown while pixel clock stands");
  property p_lead;
    !fast && $rose(lock_out) |-> $past(pclk_out, 8) && !$past(pclk_out, 9);
  endproperty
  a_lead: assert property (p_lead)
    else $error("lock not eight edges after clock start");
  property p_fast_first;
    fast && $rose(pclk_out) && !$past(lock_out) |-> lock_out;
  endproperty
  a_fast_first: assert property (p_fast_first)
    else $error("clock started before lock in high-freq mode");
  property p_fast_lock;
    fast && $rose(lock_out) |-> $rose(pclk_out);
  endproperty
  a_fast_lock: assert property (p_fast_lock)
    else $error("lock without clock start in high-freq mode");
  // a launch must never land on the edge the receiver samples
  property p_edge;
    $past(link_locked) && $changed(pix)
      |-> pclk_out != strobe_edge_select && $changed(pclk_out);
  endproperty
  a_edge: assert property (p_edge)
    else $error("pixel changed on the strobe edge");
  property p_hold;
    $past(link_locked) && $changed(pix)
      |=> $stable(pix) || !$past(link_locked);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pixel held less than one clock period");
  property p_aux;
    $past(rst_n) |-> aux_pin_oe == $past(aux_is_output)
      && aux_pin_o == $past(aux_is_output & aux_local_val);
  endproperty
  a_aux: assert property (p_aux)
    else $error("aux pin drive does not follow its setting");
  c_fast: cover property (fast && $rose(lock_out));
  c_lead: cover property (!fast && $rose(lock_out));
  c_aux: cover property (aux_pin_oe == 2'h3);
endmodule

bind desvo_top desvo_top_chk desvo_top_chk_i (.sys_clk, .rst_n,
  .link_locked, .mode, .strobe_edge_select, .parallel_data_out,
  .line_sync, .frame_sync, .pclk_out, .lock_out, .aux_is_output,
  .aux_local_val, .aux_pin_o, .aux_pin_oe);

// [verification/desvo_top_tb_top.sv]
// self-checking bench for the parallel video output stage
`timescale 1ns/1ps
module desvo_top_tb_top;
  logic        sys_clk, rst_n, pix_valid, pix_line_sync, pix_frame_sync;
  logic        link_locked, strobe_edge_select, pix_ready, line_sync;
  logic        frame_sync, pclk_out, lock_out, video_stall;
  logic [11:0] pix_data, parallel_data_out;
  logic [1:0]  mode, aux_is_output, aux_local_val, ext_aux, stall_mode;
  logic [1:0]  aux_pin_o, aux_pin_oe, fwd_remote_aux_output;
  logic [13:0] exp_q[$];
  int          bad_count, cmp_count, seq;
  // pin level: our driver wins where enabled, else the outside drives it
  wire  [1:0]  aux_pin_i = aux_pin_oe & aux_pin_o | ~aux_pin_oe & ext_aux;

  desvo_top desvo_top_i (.sys_clk, .rst_n, .pix_valid, .pix_data,
    .pix_line_sync, .pix_frame_sync, .pix_ready, .link_locked, .mode,
    .strobe_edge_select, .parallel_data_out, .line_sync, .frame_sync,
    .pclk_out, .lock_out, .video_stall, .aux_is_output, .aux_local_val,
    .aux_pin_i, .aux_pin_o, .aux_pin_oe, .fwd_remote_aux_output);
  desvo_sink desvo_sink_i (.sys_clk, .pclk_out, .lock_out,
    .strobe_edge_select, .parallel_data_out, .line_sync, .frame_sync,
    .stall_mode, .video_stall);

  // 25 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp_val(input string what, input logic [13:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_cnt(input string what, input int e, g);
    cmp_count++;
    if (g != e) begin
      bad_count++;
      $display("unexpected %s: expected %0d seen %0d", what, e, g);
    end
  endtask

  // a wait that runs out is counted and ends the run
  task automatic bound(input string what, inout int k, input int lim);
    k++;
    if (k > lim) begin
      cmp_cnt(what, lim, k);
      results();
    end
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // hold the word until taken; idle data is inverted so it is not reused
  task automatic send(input logic [13:0] w);
    int k;
    k = 0;
    repeat ($urandom_range(2)) @(posedge sys_clk);
    @(posedge sys_clk);
    pix_valid <= 1'b1;
    {pix_data, pix_line_sync, pix_frame_sync} <= w;
    // ready seen settled after an edge is what the next edge samples
    #1;
    while (pix_ready !== 1'b1) begin
      tick();
      bound("pix_ready wait", k, 300);
    end
    @(posedge sys_clk);
    pix_valid <= 1'b0;
    {pix_data, pix_line_sync, pix_frame_sync} <= ~w;
    exp_q.push_back(mode == desvo_pkg::MODE_TEN_BIT ? w & 14'h0fff : w);
  endtask

  // numbered words so a new pixel never looks like a repeated one
  task automatic burst(input int cnt);
    logic [13:0] w;
    repeat (cnt) begin
      seq++;
      w = {4'($urandom), 8'(seq), 2'($urandom)};
      if (mode == desvo_pkg::MODE_TEN_BIT)
        w[1:0] = {1'((seq / 10) % 2), 1'((seq / 20) % 2)};
      send(w);
    end
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (desvo_sink_i.got_q.size() < exp_q.size()) begin
      tick();
      bound("pixels seen", k, 600);
    end
    while (exp_q.size() > 0)
      cmp_val("pixel", exp_q.pop_front(),
              desvo_sink_i.got_q.pop_front());
    cmp_cnt("extra pixels", 0, desvo_sink_i.got_q.size());
  endtask

  // drop the link, reconfigure, lock again and stream a burst
  task automatic phase(input logic [1:0] m, input logic sel);
    int k;
    @(posedge sys_clk);
    link_locked <= 1'b0;
    repeat (3) @(posedge sys_clk);
    mode <= m;
    strobe_edge_select <= sel;
    stall_mode <= 2'($urandom_range(1));
    repeat (3) @(posedge sys_clk);
    link_locked <= 1'b1;
    k = 0;
    do begin
      tick();
      bound("pclk start", k, 20);
    end while (pclk_out !== 1'b1);
    k = 0;
    while (lock_out !== 1'b1) begin
      tick();
      bound("lock start", k, 40);
    end
    cmp_cnt("lock lead", m == desvo_pkg::MODE_HIGH_FREQ ? 0 :
            int'(desvo_pkg::LEAD_CYCLES), k);
    burst(12);
    drain();
  endtask

  initial begin
    rst_n = 1'b0;
    {pix_valid, pix_data, pix_line_sync, pix_frame_sync} = '0;
    {link_locked, strobe_edge_select, mode, stall_mode} = '0;
    {aux_is_output, aux_local_val, ext_aux} = '0;
    bad_count = 0;
    cmp_count = 0;
    seq = 0;
    void'($urandom(55445));
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) tick();
    cmp_val("pix_ready", 14'h0001, 14'(pix_ready));
    // aux pins: random direction, local value and outside level
    repeat (6) begin
      @(posedge sys_clk);
      {aux_is_output, aux_local_val, ext_aux} <= 6'($urandom);
      repeat (5) tick();
      cmp_val("aux_pin_oe", 14'(aux_is_output), 14'(aux_pin_oe));
      cmp_val("aux_pin_o", 14'(aux_is_output & aux_local_val),
              14'(aux_pin_o));
      cmp_val("fwd_remote_aux_output", 14'(ext_aux & ~aux_is_output),
              14'(fwd_remote_aux_output));
    end
    // codes 0, 1, 2 cover ten-bit, low and high frequency, both edges
    for (int i = 0; i < 6; i++)
      phase(2'(i / 2), 1'(i % 2));
    // far side holds off: two words fill the buffer, a third is refused
    @(posedge sys_clk);
    stall_mode <= 2'h2;
    repeat (6) @(posedge sys_clk);
    burst(2);
    tick();
    cmp_val("pix_ready", 14'h0000, 14'(pix_ready));
    @(posedge sys_clk);
    stall_mode <= 2'h1;
    burst(3);
    drain();
    results();
  end
endmodule
